// >>> hdl/socket_irq_window_pkg.sv
package socket_irq_window_pkg;

  localparam int SOCKET_COUNT = 2;

  // Legacy index space: socket B sits one stride above socket A
  localparam logic [7:0] IDX_STATUS = 8'h04;
  localparam logic [7:0] IDX_IRQ_CONFIG = 8'h05;
  localparam logic [7:0] IDX_WINDOW_ENABLE = 8'h06;
  localparam logic [7:0] LEGACY_SOCKET_STRIDE = 8'h40;
  // Mapped space: socket base plus this page
  localparam logic [3:0] MAPPED_PAGE = 4'h8;

  localparam logic [7:0] IRQ_CONFIG_RESET = 8'h00;
  localparam logic [7:0] WINDOW_ENABLE_RESET = 8'h00;
  localparam logic [7:0] WINDOW_ENABLE_WRITABLE = 8'hDF;

  // Field positions of the interrupt configuration register
  localparam int ROUTE_MSB = 7;
  localparam int ROUTE_LSB = 4;
  localparam int CARD_DETECT_EN_BIT = 3;
  localparam int READY_RISE_EN_BIT = 2;
  localparam int BATTERY_WARN_EN_BIT = 1;
  localparam int BATTERY_DEAD_EN_BIT = 0;

  // Field positions of the window enable register
  localparam int IO_WINDOW_ONE_BIT = 7;
  localparam int IO_WINDOW_ZERO_BIT = 6;
  localparam int WINDOW_RESERVED_BIT = 5;
  localparam int MEM_WINDOW_COUNT = 5;
  localparam int IO_WINDOW_COUNT = 2;

  localparam logic [3:0] ROUTE_NONE = 4'h0;
  localparam logic [3:0] ROUTE_SYSTEM_MGMT = 4'h2;

  typedef struct packed {
    logic cardDetectA;
    logic cardDetectB;
    logic ready;
    logic batteryWarn;
    logic batteryDead;
  } card_pins_type;

  typedef struct packed {
    logic [MEM_WINDOW_COUNT-1:0] memHit;
    logic [IO_WINDOW_COUNT-1:0] ioHit;
  } window_hit_type;

  typedef struct packed {
    logic [MEM_WINDOW_COUNT-1:0] memAck;
    logic [IO_WINDOW_COUNT-1:0] ioAck;
  } window_ack_type;

  typedef struct packed {
    logic [SOCKET_COUNT-1:0][7:0] irqConfig;
    logic [SOCKET_COUNT-1:0][7:0] windowEnable;
    logic [SOCKET_COUNT-1:0][3:0] flags;
    logic [SOCKET_COUNT-1:0] pinsValid;
    card_pins_type [SOCKET_COUNT-1:0] prevPins;
    logic [7:0] readData;
    logic readValid;
  } state_type;

endpackage

// >>> hdl/card_status_irq_and_window_enable.sv
// How it works
// - Route code 0 with diagnostic bit set sends status interrupts to PCI.
// - Route code 0, diagnostic clear: PCI only when socket control bit 4 set.
// - Nonzero route codes select system management (0010), a legacy line, or nothing (0111, 1010, 1110).
// - Card detect enable lets either detect line change set a flag.
// - Ready enable lets a ready rising edge set a flag.
// - Battery warning enable lets a battery warning rising edge set a flag.
// - Battery dead enable lets a battery dead rising edge set a flag.
// - Window enable register resets to 00h, all windows off.
// - A card cycle is acknowledged only when its window is enabled.
// - Bits 7 and 6 enable I/O windows 1 and 0.
// - Bits 4 to 0 enable memory windows 4 to 0.
// - Window enable bit 5 reads 0 and ignores writes.
// - Per socket interrupt config at 05h, 45h, base+805h; resets to 00h.
// - Per socket window enable at 06h, 46h, base+806h.
// - A flag latches only when enabled; a disabled flag reads 0.
// - Flags clear by status read or by writing 1, per clear mode input.
module card_status_irq_and_window_enable (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic regMapped,
  input wire logic [socket_irq_window_pkg::SOCKET_COUNT-1:0] regSocket,
  input wire logic [11:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  output logic regReadValid,
  input wire logic clearByWriteMode,
  input wire logic diagRouteToPci,
  input wire logic [socket_irq_window_pkg::SOCKET_COUNT-1:0] socketPciCscEn,
  input socket_irq_window_pkg::card_pins_type
    [socket_irq_window_pkg::SOCKET_COUNT-1:0] cardPins,
  input socket_irq_window_pkg::window_hit_type
    [socket_irq_window_pkg::SOCKET_COUNT-1:0] windowHit,
  output socket_irq_window_pkg::window_ack_type
    [socket_irq_window_pkg::SOCKET_COUNT-1:0] windowAck,
  output logic [socket_irq_window_pkg::SOCKET_COUNT-1:0][7:0]
    windowEnableOut,
  output logic [15:0] legacyIrq,
  output logic systemMgmtInterrupt,
  output logic [socket_irq_window_pkg::SOCKET_COUNT-1:0] pciCscRequest
);
  import socket_irq_window_pkg::*;

  state_type state;
  state_type next_state;

  logic hit;
  logic [SOCKET_COUNT-1:0] sockSel;
  logic [7:0] index;
  logic [SOCKET_COUNT-1:0][3:0] events;
  logic [SOCKET_COUNT-1:0][3:0] enables;
  logic [SOCKET_COUNT-1:0] pending;
  logic [11:0] legacyLow;
  logic [11:0] legacyHigh;

  // Per socket pin edges, register selects and views
  logic [SOCKET_COUNT-1:0] detectChange;
  logic [SOCKET_COUNT-1:0] readyRise;
  logic [SOCKET_COUNT-1:0] warnRise;
  logic [SOCKET_COUNT-1:0] deadRise;
  logic [SOCKET_COUNT-1:0] readSel;
  logic [SOCKET_COUNT-1:0] writeSel;
  logic [SOCKET_COUNT-1:0][3:0] statusView;
  logic [SOCKET_COUNT-1:0][3:0] clearMask;
  logic [SOCKET_COUNT-1:0][7:0] windowView;
  logic [SOCKET_COUNT-1:0][7:0] windowWrite;

  // Per socket window enables and interrupt route decode
  logic [SOCKET_COUNT-1:0][MEM_WINDOW_COUNT-1:0] memWindowEn;
  logic [SOCKET_COUNT-1:0][IO_WINDOW_COUNT-1:0] ioWindowEn;
  logic [SOCKET_COUNT-1:0][3:0] routeCode;
  logic [SOCKET_COUNT-1:0] routeToPci;
  logic [SOCKET_COUNT-1:0] routeToMgmt;
  logic [SOCKET_COUNT-1:0][15:0] routeLines;

  // Only the printed codes drive a legacy line; the rest go nowhere
  function automatic logic [15:0] legacyLine(input logic [3:0] code);
    logic [15:0] line;
    line = 16'h0000;
    unique case (code)
      4'h1: begin
        line[1] = 1'b1;
      end
      4'h3: begin
        line[3] = 1'b1;
      end
      4'h4: begin
        line[4] = 1'b1;
      end
      4'h5: begin
        line[5] = 1'b1;
      end
      4'h6: begin
        line[6] = 1'b1;
      end
      4'h8: begin
        line[8] = 1'b1;
      end
      4'h9: begin
        line[10] = 1'b1;
      end
      4'hB: begin
        line[11] = 1'b1;
      end
      4'hC: begin
        line[12] = 1'b1;
      end
      4'hD: begin
        line[13] = 1'b1;
      end
      4'hF: begin
        line[15] = 1'b1;
      end
      default: line = 16'h0000;
    endcase
    return line;
  endfunction

  // Address decode for both the legacy index and the mapped page
  always_comb begin
    hit = 1'b0;
    sockSel = '0;
    index = 8'h00;
    legacyLow = 12'h000;
    legacyHigh = 12'h000;
    if (regMapped) begin
      // A socket number past the fitted count selects nothing
      hit = (regAddr[11:8] == MAPPED_PAGE) &&
        (regSocket < SOCKET_COUNT'(SOCKET_COUNT));
      sockSel = regSocket;
      index = regAddr[7:0];
    end else begin
      for (int s = 0; s < SOCKET_COUNT; s++) begin
        legacyLow = {4'h0, 8'(s) * LEGACY_SOCKET_STRIDE};
        legacyHigh = {4'h0, 8'(s + 1) * LEGACY_SOCKET_STRIDE};
        if (regAddr >= legacyLow && regAddr < legacyHigh) begin
          hit = 1'b1;
          sockSel = SOCKET_COUNT'(s);
          index = regAddr[7:0] - 8'(s) * LEGACY_SOCKET_STRIDE;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < SOCKET_COUNT; g++) begin : gen_socket
      // Enables in status bit order: detect, ready, warn, dead
      assign enables[g] = {
        state.irqConfig[g][CARD_DETECT_EN_BIT],
        state.irqConfig[g][READY_RISE_EN_BIT],
        state.irqConfig[g][BATTERY_WARN_EN_BIT],
        state.irqConfig[g][BATTERY_DEAD_EN_BIT]};

      // Either detect line moving counts as one change
      assign detectChange[g] =
        (cardPins[g].cardDetectA ^ state.prevPins[g].cardDetectA) |
        (cardPins[g].cardDetectB ^ state.prevPins[g].cardDetectB);
      assign readyRise[g] =
        cardPins[g].ready & ~state.prevPins[g].ready;
      assign warnRise[g] =
        cardPins[g].batteryWarn & ~state.prevPins[g].batteryWarn;
      assign deadRise[g] =
        cardPins[g].batteryDead & ~state.prevPins[g].batteryDead;
      // Edges are ignored until the first pin sample after reset
      assign events[g] = state.pinsValid[g] ?
        {detectChange[g], readyRise[g], warnRise[g], deadRise[g]} : 4'h0;
      // The interrupt stands while any enabled flag is still latched
      assign pending[g] = |(state.flags[g] & enables[g]);
      assign statusView[g] = state.flags[g] & enables[g];

      // Register selects; a read and a write may share one cycle
      assign readSel[g] = hit && regRead &&
        (sockSel == SOCKET_COUNT'(g));
      assign writeSel[g] = hit && regWrite &&
        (sockSel == SOCKET_COUNT'(g));
      // Write-one-to-clear pattern, honoured only in that mode
      assign clearMask[g] = clearByWriteMode ? regWriteData[3:0] : 4'h0;
      // Reserved bit is never stored and never shown
      assign windowWrite[g] = regWriteData & WINDOW_ENABLE_WRITABLE;
      assign windowView[g] = state.windowEnable[g] &
        WINDOW_ENABLE_WRITABLE;

      // Route decode
      assign routeCode[g] = state.irqConfig[g][ROUTE_MSB:ROUTE_LSB];
      assign routeToPci[g] = (routeCode[g] == ROUTE_NONE) &&
        (diagRouteToPci || socketPciCscEn[g]);
      assign routeToMgmt[g] = (routeCode[g] == ROUTE_SYSTEM_MGMT);
      assign routeLines[g] = legacyLine(routeCode[g]);

      // Disabled windows never acknowledge, whatever the decoders say
      assign memWindowEn[g] =
        state.windowEnable[g][MEM_WINDOW_COUNT-1:0];
      assign ioWindowEn[g] = {
        state.windowEnable[g][IO_WINDOW_ONE_BIT],
        state.windowEnable[g][IO_WINDOW_ZERO_BIT]};
      assign windowAck[g].memAck = windowHit[g].memHit &
        memWindowEn[g];
      assign windowAck[g].ioAck = windowHit[g].ioHit & ioWindowEn[g];
      // Window enables are exported for the cycle decoders
      assign windowEnableOut[g] = state.windowEnable[g];
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_state.readValid = 1'b0;
    // Pins are sampled every cycle so each edge is seen once
    for (int s = 0; s < SOCKET_COUNT; s++) begin
      next_state.prevPins[s] = cardPins[s];
      next_state.pinsValid[s] = 1'b1;
    end
    if (regRead) begin
      next_state.readValid = 1'b1;
      next_state.readData = 8'h00;
    end

    // Register accesses first, then fresh events on top of any clear
    for (int s = 0; s < SOCKET_COUNT; s++) begin
      if (readSel[s]) begin
        unique case (index)
          IDX_STATUS: begin
            next_state.readData = {4'h0, statusView[s]};
            if (!clearByWriteMode) begin
              next_state.flags[s] = 4'h0;
            end
          end
          IDX_IRQ_CONFIG: begin
            next_state.readData = state.irqConfig[s];
          end
          IDX_WINDOW_ENABLE: begin
            next_state.readData = windowView[s];
          end
          default: begin
            next_state.readData = 8'h00;
          end
        endcase
      end

      if (writeSel[s]) begin
        unique case (index)
          IDX_STATUS: begin
            next_state.flags[s] = next_state.flags[s] &
              ~clearMask[s];
          end
          IDX_IRQ_CONFIG: begin
            next_state.irqConfig[s] = regWriteData;
          end
          IDX_WINDOW_ENABLE: begin
            next_state.windowEnable[s] = windowWrite[s];
          end
          default: begin
            // Unmapped indices are ignored
            next_state.irqConfig[s] = next_state.irqConfig[s];
          end
        endcase
      end
      // A new event wins over a clear in the same cycle
      next_state.flags[s] = (next_state.flags[s] | events[s]) &
        enables[s];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
      // Windows start closed so no cycle reaches an unset socket
      for (int s = 0; s < SOCKET_COUNT; s++) begin
        state.irqConfig[s] <= IRQ_CONFIG_RESET;
        state.windowEnable[s] <= WINDOW_ENABLE_RESET;
      end
    end else begin
      state <= next_state;
    end
  end

  // Interrupt routing, merged over sockets
  always_comb begin
    legacyIrq = 16'h0000;
    systemMgmtInterrupt = 1'b0;
    pciCscRequest = '0;
    // Outputs are levels: they follow the flags, not the events
    for (int s = 0; s < SOCKET_COUNT; s++) begin
      if (pending[s]) begin
        // Codes 0000 and 0010 select no legacy line
        legacyIrq = legacyIrq | routeLines[s];
        if (routeToMgmt[s]) begin
          systemMgmtInterrupt = 1'b1;
        end
        if (routeToPci[s]) begin
          pciCscRequest[s] = 1'b1;
        end
      end
    end
  end

  assign regReadData = state.readData;
  assign regReadValid = state.readValid;

endmodule

// >>> verif/card_pin_model.sv
module card_pin_model (
  input wire logic sys_clk,
  input wire logic rst,
  input socket_irq_window_pkg::card_pins_type want,
  output socket_irq_window_pkg::card_pins_type pins
);
  import socket_irq_window_pkg::*;
  // Card status lines settle one clock after the card changes state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins <= '0;
    end else begin
      pins <= want;
    end
  end
endmodule

// >>> verif/card_status_irq_and_window_enable_sva.sv
module card_status_irq_and_window_enable_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic regMapped,
  input wire logic [11:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWriteData,
  input wire logic regReadValid,
  input socket_irq_window_pkg::window_hit_type [1:0] windowHit,
  input socket_irq_window_pkg::window_ack_type [1:0] windowAck,
  input wire logic [1:0][7:0] windowEnableOut,
  input wire logic [15:0] legacyIrq
);
  import socket_irq_window_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence win_wr_s;
    regWrite && !regMapped && regAddr == 12'h006;
  endsequence
  win_ack_a: assert property (
    windowAck[0] == {windowHit[0].memHit & windowEnableOut[0][4:0],
    windowHit[0].ioHit & windowEnableOut[0][7:6]}) else $error("bad ack");
  rsvd_bit_a: assert property (
    !windowEnableOut[0][5] && !windowEnableOut[1][5]) else $error("bit 5");
  dead_lines_a: assert property (
    {legacyIrq[14], legacyIrq[9], legacyIrq[7], legacyIrq[2], legacyIrq[0]}
    == 5'h00) else $error("unrouted irq line");
  reset_state_a: assert property (
    $fell(rst) |-> windowEnableOut == 16'h0000 && legacyIrq == 16'h0000)
    else $error("reset state");
  win_write_a: assert property (
    win_wr_s |=> windowEnableOut[0] == ($past(regWriteData) & 8'hDF))
    else $error("window write lost");
  win_hold_a: assert property (
    !regWrite |=> $stable(windowEnableOut)) else $error("window changed");
  read_ans_a: assert property (
    regRead |=> regReadValid) else $error("no read answer");
  read_quiet_a: assert property (
    !regRead |=> !regReadValid) else $error("stray read answer");
endmodule
bind card_status_irq_and_window_enable card_status_irq_and_window_enable_sva
  chk (.sys_clk, .rst, .regMapped, .regAddr, .regWrite, .regRead,
  .regWriteData, .regReadValid, .windowHit, .windowAck, .windowEnableOut,
  .legacyIrq);

// >>> verif/card_status_irq_and_window_enable_tb_top.sv
module card_status_irq_and_window_enable_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import socket_irq_window_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, regMapped = 1'b0, regWrite = 1'b0;
  logic regRead = 1'b0, clearByWriteMode = 1'b0, diagRouteToPci = 1'b1;
  logic regReadValid, systemMgmtInterrupt;
  logic [1:0] regSocket = 2'h0, socketPciCscEn = 2'h0, pciCscRequest;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWriteData = 8'h00, regReadData;
  logic [15:0] legacyIrq;
  logic [1:0][7:0] windowEnableOut;
  card_pins_type want = '0, cardA;
  window_hit_type [1:0] windowHit = '1;
  window_ack_type [1:0] windowAck;
  int fails = 0, cmp_count = 0;
  card_status_irq_and_window_enable dut (.sys_clk, .rst, .regMapped,
    .regSocket, .regAddr, .regWrite, .regRead, .regWriteData, .regReadData,
    .regReadValid, .clearByWriteMode, .diagRouteToPci, .socketPciCscEn,
    .cardPins({5'h00, cardA}), .windowHit, .windowAck, .windowEnableOut,
    .legacyIrq, .systemMgmtInterrupt, .pciCscRequest);
  card_pin_model card (.sys_clk, .rst, .want, .pins(cardA));
  always #25 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic m, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regMapped <= m;
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic m, input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regMapped <= m;
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk);
    check({regReadValid, 7'h00, regReadData}, {8'h80, e});
  endtask
  task automatic t_regs;
    rd(1'h0, 12'h005, 8'h00);
    rd(1'h0, 12'h046, 8'h00);
    wr(1'h0, 12'h006, 8'hFF);
    rd(1'h0, 12'h006, 8'hDF);
    wr(1'h1, 12'h806, 8'h55);
    rd(1'h0, 12'h046, 8'h55);
    wr(1'h0, 12'h012, 8'hFF);
    rd(1'h0, 12'h012, 8'h00);
    check({2'h0, windowAck}, 16'h2AFF);
    $display("register test done");
  endtask
  task automatic t_route;
    logic [15:0] e;
    for (int c = 0; c < 16; c++) begin
      wr(1'h0, 12'h005, {c[3:0], 4'h8});
      want.cardDetectB <= ~want.cardDetectB;
      tick(3);
      e = 16'h0000;
      if (c == 9) begin
        e[10] = 1'b1;
      end else if (!(c inside {0, 2, 7, 10, 14})) begin
        e[c] = 1'b1;
      end
      check(legacyIrq, e);
      check({systemMgmtInterrupt, pciCscRequest},
        {c == 2, 1'h0, c == 0});
      rd(1'h0, 12'h004, 8'h08);
      check(legacyIrq, 16'h0000);
    end
    wr(1'h0, 12'h005, 8'h08);
    diagRouteToPci <= 1'b0;
    want.cardDetectA <= ~want.cardDetectA;
    tick(3);
    check({14'h0, pciCscRequest}, 16'h0000);
    @(posedge sys_clk);
    socketPciCscEn <= 2'h1;
    tick(0);
    check({14'h0, pciCscRequest}, 16'h0001);
    $display("routing test done");
  endtask
  task automatic t_mask;
    wr(1'h0, 12'h005, 8'h30);
    want <= 5'h1F;
    tick(3);
    check(legacyIrq, 16'h0000);
    rd(1'h0, 12'h004, 8'h00);
    wr(1'h0, 12'h005, 8'h30);
    want <= '0;
    for (int b = 0; b < 3; b++) begin
      wr(1'h0, 12'h005, 8'h30 | 8'(1 << b));
      want <= card_pins_type'(5'(1 << b));
      clearByWriteMode <= 1'b1;
      tick(3);
      check(legacyIrq, 16'h0008);
      rd(1'h0, 12'h004, 8'(1 << b));
      wr(1'h0, 12'h004, 8'(1 << b));
      want <= '0;
      clearByWriteMode <= 1'b0;
      tick(3);
      check(legacyIrq, 16'h0000);
    end
    $display("mask test done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    regSocket <= 2'h1;
    t_regs;
    t_route;
    t_mask;
    final_report;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    final_report;
  end
endmodule
